/* File: inc/eacalc_pkg.sv */
// constants and types for the effective address calculator
`default_nettype none
package eacalc_pkg;
   localparam int AW       = 32;          // address and data width
   localparam int RSEL_W   = 3;           // register number width
   localparam int NREGS    = 8;           // registers per bank
   localparam int BYTE_W   = 8;           // short byte displacement width
   localparam int WORD_W   = 16;          // word width
   localparam int SCALE_W  = 2;           // scale field width
   localparam logic [1:0] SZ_BYTE = 2'h0; // operand size byte
   localparam logic [1:0] SZ_WORD = 2'h1; // operand size word
   localparam logic [1:0] SZ_LONG = 2'h2; // operand size long
   localparam logic [1:0] DSZ_NONE = 2'h0; // displacement suppressed
   localparam logic [1:0] DSZ_WORD = 2'h1; // 16-bit displacement
   localparam logic [1:0] DSZ_LONG = 2'h2; // 32-bit displacement
   localparam logic [AW-1:0] RESET_ADDR = 32'h0000_0000; // result after reset

   // the eighteen addressing modes
   typedef enum logic [4:0] {
      EAC_DREG, EAC_AREG, EAC_AIND, EAC_APOST, EAC_APRE, EAC_ADISP,
      EAC_AIDX8, EAC_AIDXB, EAC_AMPOST, EAC_AMPRE, EAC_PCDISP, EAC_PCIDX8,
      EAC_PCIDXB, EAC_PCMPOST, EAC_PCMPRE, EAC_ABSW, EAC_ABSL, EAC_IMM
   } eacalc_mode_t;
endpackage
`default_nettype wire

/* File: hw/eacalc.sv */
// effective address calculator with memory indirection fetch
`timescale 1ns/1ps
`default_nettype none
module eacalc (
   input  wire logic                         core_clk,      // core clock, 40 MHz
   input  wire logic                         rst_b,         // async reset, active low
   input  wire logic                         clk_en,        // freezes all state when low
   input  wire logic                         start,         // pulse: begin calculation
   input  wire eacalc_pkg::eacalc_mode_t     mode,          // addressing mode
   input  wire logic [2:0]                   data_reg_sel,  // data register number
   input  wire logic [2:0]                   addr_reg_sel,  // address register number
   input  wire logic [2:0]                   index_reg_sel, // index register number
   input  wire logic                         index_is_addr, // index bank: 1 address
   input  wire logic                         index_long,    // index size: 1 long
   input  wire logic [1:0]                   index_scale,   // scale code
   input  wire logic                         index_supp,    // index suppressed
   input  wire logic [1:0]                   bd_size,       // base_disp size code
   input  wire logic [1:0]                   od_size,       // outer_disp size code
   input  wire logic [1:0]                   op_size,       // operand size
   input  wire logic [7:0]                   short_disp_byte, // 8-bit displacement
   input  wire logic [15:0]                  short_disp_word, // 16-bit displacement
   input  wire logic [31:0]                  base_disp,     // base displacement
   input  wire logic [31:0]                  outer_disp,    // outer displacement
   input  wire logic [31:0]                  ext_data,      // absolute or immediate data
   input  wire logic [31:0]                  pc,            // program counter of extension
   input  wire logic [8*32-1:0]              dregs,         // data registers packed
   input  wire logic [8*32-1:0]              aregs,         // address registers packed
   output logic                              fetch_req,     // long-word read request
   output logic [31:0]                       fetch_addr,    // read address
   input  wire logic                         fetch_ack,     // read done pulse
   input  wire logic [31:0]                  fetch_data,    // read long word
   output logic                              busy,          // indirection fetch in progress
   output logic                              done,          // pulse: result valid
   output logic                              ea_is_reg,     // result names a register
   output logic                              ea_is_imm,     // result is immediate value
   output logic [31:0]                       ea_result,     // address, value or reg number
   output logic                              areg_wb,       // pulse: write back pointer
   output logic [2:0]                        areg_wb_sel,   // pointer register number
   output logic [31:0]                       areg_wb_val    // updated pointer value
);
   import eacalc_pkg::*;

   typedef enum {EAC_IDLE, EAC_FETCH} eacalc_state_t;

   eacalc_state_t   state_ff;       // sequencer state
   logic [AW-1:0]   post_add_ff;    // terms added after the fetch
   logic [AW-1:0]   fetch_addr_ff;  // inner address held during fetch

   // sign-extend a displacement by size code, zero when suppressed
   function automatic logic [AW-1:0] disp_ext(input logic [1:0] sz, input logic [AW-1:0] v);
      unique case (sz)
         DSZ_WORD: disp_ext = {{(AW-WORD_W){v[WORD_W-1]}}, v[WORD_W-1:0]};
         DSZ_LONG: disp_ext = v;
         default:  disp_ext = '0;
      endcase
   endfunction

   // pick a register out of a packed bank of eight
   function automatic logic [AW-1:0] reg_pick(input logic [NREGS*AW-1:0] bank, input logic [2:0] n);
      reg_pick = bank[n*AW +: AW];
   endfunction

   logic [AW-1:0] an_val;      // selected address register
   logic [AW-1:0] dn_val;      // selected data register
   logic [AW-1:0] idx_raw;     // raw index register
   logic [AW-1:0] idx_sized;   // index after size selection
   logic [AW-1:0] idx_scaled;  // index after scaling
   logic [AW-1:0] d8_ext;      // sign-extended byte displacement
   logic [AW-1:0] d16_ext;     // sign-extended word displacement
   logic [AW-1:0] bd_ext;      // base displacement term
   logic [AW-1:0] od_ext;      // outer displacement term
   logic [AW-1:0] step;        // pointer step by operand size
   logic [AW-1:0] imm_val;     // immediate by operand size

   assign an_val  = reg_pick(aregs, addr_reg_sel);
   assign dn_val  = reg_pick(dregs, data_reg_sel);
   assign idx_raw = index_is_addr ? reg_pick(aregs, index_reg_sel)
                                  : reg_pick(dregs, index_reg_sel);
   assign idx_sized = index_long ? idx_raw
                    : {{(AW-WORD_W){idx_raw[WORD_W-1]}}, idx_raw[WORD_W-1:0]};
   // scaling is a shift; zero when the index is suppressed
   assign idx_scaled = index_supp ? '0 : (idx_sized << index_scale);
   assign d8_ext  = {{(AW-BYTE_W){short_disp_byte[BYTE_W-1]}}, short_disp_byte};
   assign d16_ext = {{(AW-WORD_W){short_disp_word[WORD_W-1]}}, short_disp_word};
   assign bd_ext  = disp_ext(bd_size, base_disp);
   assign od_ext  = disp_ext(od_size, outer_disp);

   // pointer step: byte 1, word 2, long 4; stack pointer keeps word alignment on bytes
   always_comb begin
      unique case (op_size)
         SZ_BYTE: step = (addr_reg_sel == 3'h7) ? 32'h0000_0002 : 32'h0000_0001;
         SZ_WORD: step = 32'h0000_0002;
         default: step = 32'h0000_0004;
      endcase
   end

   // immediate operand trimmed to the operand size
   always_comb begin
      unique case (op_size)
         SZ_BYTE: imm_val = {24'h00_0000, ext_data[7:0]};
         SZ_WORD: imm_val = {16'h0000, ext_data[15:0]};
         default: imm_val = ext_data;
      endcase
   end

   // one-cycle result for direct modes, inner address for indirect ones
   logic [AW-1:0] calc_addr;   // final or inner address
   logic          calc_mem;    // mode needs an indirection fetch
   logic [AW-1:0] calc_post;   // terms added after fetch
   logic          calc_reg;    // result is a register number
   logic          calc_imm;    // result is an immediate
   logic          calc_wb;     // pointer write-back
   logic [AW-1:0] calc_wbv;    // pointer write-back value
   logic [AW-1:0] base_sel;    // pointer base for memory indirect

   always_comb begin
      calc_addr = '0;
      calc_mem  = 1'b0;
      calc_post = '0;
      calc_reg  = 1'b0;
      calc_imm  = 1'b0;
      calc_wb   = 1'b0;
      calc_wbv  = an_val;
      base_sel  = (mode == EAC_PCMPOST || mode == EAC_PCMPRE) ? pc : an_val;
      unique case (mode)
         EAC_DREG:   begin calc_addr = {29'h0, data_reg_sel}; calc_reg = 1'b1; end
         EAC_AREG:   begin calc_addr = {29'h0, addr_reg_sel}; calc_reg = 1'b1; end
         EAC_AIND:   calc_addr = an_val;
         EAC_APOST:  begin
            calc_addr = an_val;
            calc_wb   = 1'b1;
            calc_wbv  = an_val + step;
         end
         EAC_APRE:   begin
            calc_addr = an_val - step;
            calc_wb   = 1'b1;
            calc_wbv  = an_val - step;
         end
         EAC_ADISP:  calc_addr = an_val + d16_ext;
         EAC_AIDX8:  calc_addr = an_val + d8_ext + idx_scaled;
         EAC_AIDXB:  calc_addr = an_val + bd_ext + idx_scaled;
         EAC_PCDISP: calc_addr = pc + d16_ext;
         EAC_PCIDX8: calc_addr = pc + d8_ext + idx_scaled;
         EAC_PCIDXB: calc_addr = pc + bd_ext + idx_scaled;
         EAC_AMPOST, EAC_PCMPOST: begin
            calc_addr = base_sel + bd_ext;
            calc_mem  = 1'b1;
            calc_post = idx_scaled + od_ext;
         end
         EAC_AMPRE, EAC_PCMPRE: begin
            calc_addr = base_sel + bd_ext + idx_scaled;
            calc_mem  = 1'b1;
            calc_post = od_ext;
         end
         EAC_ABSW:   calc_addr = d16_ext;                              // short absolute
         EAC_ABSL:   calc_addr = ext_data;                             // long absolute
         EAC_IMM:    begin calc_addr = imm_val; calc_imm = 1'b1; end
         default:    calc_addr = '0;                                   // illegal code
      endcase
   end

   // sequencer: direct modes finish in one cycle, indirect wait for the long-word read
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff      <= EAC_IDLE;
         post_add_ff   <= '0;
         fetch_addr_ff <= RESET_ADDR;
      end else if (clk_en) begin
         unique case (state_ff)
            EAC_IDLE: if (start && calc_mem) begin
               state_ff      <= EAC_FETCH;
               fetch_addr_ff <= calc_addr;
               post_add_ff   <= calc_post;
            end
            EAC_FETCH: if (fetch_ack) begin
               state_ff <= EAC_IDLE;
            end
         endcase
      end
   end

   // result and write-back outputs
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         done        <= 1'b0;
         ea_is_reg   <= 1'b0;
         ea_is_imm   <= 1'b0;
         ea_result   <= RESET_ADDR;
         areg_wb     <= 1'b0;
         areg_wb_sel <= 3'h0;
         areg_wb_val <= RESET_ADDR;
      end else if (clk_en) begin
         done    <= 1'b0;
         areg_wb <= 1'b0;
         if (state_ff == EAC_IDLE && start && !calc_mem) begin
            done        <= 1'b1;
            ea_is_reg   <= calc_reg;
            ea_is_imm   <= calc_imm;
            ea_result   <= calc_addr;
            areg_wb     <= calc_wb;
            areg_wb_sel <= addr_reg_sel;
            areg_wb_val <= calc_wbv;
         end else if (state_ff == EAC_FETCH && fetch_ack) begin
            done      <= 1'b1;
            ea_is_reg <= 1'b0;
            ea_is_imm <= 1'b0;
            ea_result <= fetch_data + post_add_ff;
         end
      end
   end

   assign fetch_req  = (state_ff == EAC_FETCH);
   assign fetch_addr = fetch_addr_ff;
   assign busy       = (state_ff == EAC_FETCH);

   property p_fetch_hold;
      @(posedge core_clk) disable iff (!rst_b)
      (fetch_req && !fetch_ack && clk_en) |=> fetch_req && $stable(fetch_addr);
   endproperty
   a_fetch_hold: assert property (p_fetch_hold) else $error("fetch dropped early");

   sequence s_fetch_end;
      fetch_req && fetch_ack && clk_en;
   endsequence
   property p_indirect_result;
      @(posedge core_clk) disable iff (!rst_b)
      s_fetch_end |=> done && ea_result == $past(fetch_data) + $past(post_add_ff);
   endproperty
   a_indirect_result: assert property (p_indirect_result) else $error("bad indirect result");

   property p_start_mem;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && calc_mem) |=> fetch_req && fetch_addr == $past(calc_addr) && !done;
   endproperty
   a_start_mem: assert property (p_start_mem) else $error("indirect start wrong");

   property p_direct_done;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && !calc_mem) |=> done && !fetch_req;
   endproperty
   a_direct_done: assert property (p_direct_done) else $error("direct mode not done");

   property p_postinc;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && mode == EAC_APOST && op_size == SZ_LONG)
         |=> areg_wb && areg_wb_val == ea_result + 32'h0000_0004;
   endproperty
   a_postinc: assert property (p_postinc) else $error("postincrement wrong");

   property p_predec;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && mode == EAC_APRE) |=> areg_wb && areg_wb_val == ea_result;
   endproperty
   a_predec: assert property (p_predec) else $error("predecrement wrong");

   property p_pcdisp;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && mode == EAC_PCDISP)
         |=> ea_result == $past(pc) + {{16{$past(short_disp_word[15])}}, $past(short_disp_word)};
   endproperty
   a_pcdisp: assert property (p_pcdisp) else $error("pc displacement wrong");

   property p_idx_supp;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && mode == EAC_AIDXB && index_supp && bd_size == DSZ_NONE)
         |=> ea_result == $past(an_val);
   endproperty
   a_idx_supp: assert property (p_idx_supp) else $error("suppressed term not zero");

   property p_imm_byte;
      @(posedge core_clk) disable iff (!rst_b)
      (clk_en && start && !busy && mode == EAC_IMM && op_size == SZ_BYTE)
         |=> ea_is_imm && ea_result[31:8] == 24'h00_0000;
   endproperty
   a_imm_byte: assert property (p_imm_byte) else $error("byte immediate too wide");
endmodule
`default_nettype wire

/* File: testbench/eacalc_bus_model.sv */
// bus controller model answering long-word indirection reads
`timescale 1ns/1ps
`default_nettype none
module eacalc_bus_model (
   input  wire logic        core_clk,   // core clock
   input  wire logic        rst_b,      // async reset, active low
   input  wire logic [3:0]  stall,      // wait cycles before answering
   input  wire logic        fetch_req,  // read request from the block
   input  wire logic [31:0] fetch_addr, // read address
   output logic             fetch_ack,  // one-cycle answer pulse
   output logic [31:0]      fetch_data  // long word, scrambled when idle
);
   logic [3:0] wait_ff; // cycles waited on the current request

   // answer after the programmed stall; outside the ack the data lines toggle
   // so a design that samples late never sees the word by luck
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         fetch_ack  <= 1'b0;
         fetch_data <= 32'h0;
         wait_ff    <= 4'h0;
      end else if (fetch_ack) begin
         // release after one cycle
         fetch_ack  <= 1'b0;
         fetch_data <= ~fetch_data;
         wait_ff    <= 4'h0;
      end else if (fetch_req && wait_ff == stall) begin
         fetch_ack  <= 1'b1;
         fetch_data <= {fetch_addr[15:0], fetch_addr[31:16]} ^ 32'hc3a5_96e1;
      end else begin
         // count the stall only while a request waits
         fetch_data <= ~fetch_data;
         wait_ff    <= fetch_req ? wait_ff + 4'h1 : 4'h0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the effective address calculator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import eacalc_pkg::*;
   logic         core_clk, rst_b, clk_en, start;           // clock and control
   eacalc_mode_t mode;                                      // addressing mode
   logic [2:0]   data_reg_sel, addr_reg_sel, index_reg_sel; // register numbers
   logic         index_is_addr, index_long, index_supp;     // index controls
   logic [1:0]   index_scale, bd_size, od_size, op_size;    // size and scale codes
   logic [7:0]   short_disp_byte;                           // byte displacement
   logic [15:0]  short_disp_word;                           // word displacement
   logic [31:0]  base_disp, outer_disp, ext_data, pc;       // extension operands
   logic [255:0] dregs, aregs;                              // register banks
   logic         fetch_req, fetch_ack, busy, done;          // handshakes
   logic         ea_is_reg, ea_is_imm, areg_wb;             // result flags
   logic [31:0]  fetch_addr, fetch_data, ea_result, areg_wb_val; // result values
   logic [2:0]   areg_wb_sel;                               // write-back register
   logic [3:0]   stall;                                     // partner delay
   logic [31:0]  lfsr_state;                                // random source
   int           n_mismatch, check_count;                   // report counters
   bit           timed_out;                                 // a bounded wait ran out

   eacalc eacalc_i (.core_clk, .rst_b, .clk_en, .start, .mode, .data_reg_sel, .addr_reg_sel,
      .index_reg_sel, .index_is_addr, .index_long, .index_scale, .index_supp, .bd_size, .od_size,
      .op_size, .short_disp_byte, .short_disp_word, .base_disp, .outer_disp, .ext_data, .pc,
      .dregs, .aregs, .fetch_req, .fetch_addr, .fetch_ack, .fetch_data, .busy, .done,
      .ea_is_reg, .ea_is_imm, .ea_result, .areg_wb, .areg_wb_sel, .areg_wb_val);
   eacalc_bus_model eacalc_bus_model_i (.core_clk, .rst_b, .stall, .fetch_req, .fetch_addr,
      .fetch_ack, .fetch_data);

   // 40 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // several shift steps per draw so successive values are not plain shifts
   function automatic logic [31:0] rnd();
      for (int i = 0; i < 7; i++) begin
         lfsr_state = {lfsr_state[30:0], lfsr_state[31] ^ lfsr_state[21] ^ lfsr_state[1] ^ lfsr_state[0]};
      end
      return lfsr_state;
   endfunction
   function automatic logic [31:0] sx16(input logic [15:0] v);
      return {{16{v[15]}}, v};
   endfunction
   // optional displacement; size code 3 counts as suppressed
   function automatic logic [31:0] dval(input logic [1:0] sz, input logic [31:0] v);
      return (sz == DSZ_WORD) ? sx16(v[15:0]) : (sz == DSZ_LONG) ? v : 32'h0;
   endfunction
   function automatic logic [31:0] mem(input logic [31:0] a);
      return {a[15:0], a[31:16]} ^ 32'hc3a5_96e1;
   endfunction

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // one operation: draw operands, start, hold start through busy, check result
   task automatic run_op(input int m, input int corner);
      logic [31:0] r, an, xr, xi, bd, od, d8, d16, step, base, e, inner;
      bit          got, seenf;
      for (int k = 0; k < 8; k++) begin
         dregs[k*32+:32] = rnd();
         aregs[k*32+:32] = rnd();
      end
      r = rnd();
      mode = eacalc_mode_t'(m);
      {data_reg_sel, addr_reg_sel, index_reg_sel} = r[8:0];
      {index_is_addr, index_long, index_scale} = r[12:9];
      index_supp = r[13] & r[14];
      {bd_size, od_size, op_size, stall} = r[24:15];
      short_disp_byte = r[31:24];
      short_disp_word = 16'(rnd() >> 7);
      base_disp = rnd();
      outer_disp = rnd();
      ext_data = rnd();
      pc = rnd();
      if (corner == 0) begin
         // extreme negative displacements, largest scale, byte step on the stack pointer
         short_disp_byte = 8'h80;
         short_disp_word = 16'h8000;
         {index_scale, index_supp, op_size, addr_reg_sel} = {2'h3, 1'b0, SZ_BYTE, 3'h7};
         {bd_size, base_disp, od_size} = {DSZ_WORD, 32'h0000_8000, 2'h3};
      end else if (corner == 1) begin
         // every optional term suppressed: only the base and short fields survive
         {index_supp, bd_size, od_size} = {1'b1, DSZ_NONE, DSZ_NONE};
      end
      an = aregs[addr_reg_sel*32+:32];
      xr = index_is_addr ? aregs[index_reg_sel*32+:32] : dregs[index_reg_sel*32+:32];
      xi = index_supp ? 32'h0 : (index_long ? xr : sx16(xr[15:0])) << index_scale;
      bd = dval(bd_size, base_disp);
      od = dval(od_size, outer_disp);
      d8 = {{24{short_disp_byte[7]}}, short_disp_byte};
      d16 = sx16(short_disp_word);
      step = (op_size == SZ_BYTE) ? ((addr_reg_sel == 3'h7) ? 32'h2 : 32'h1) :
             (op_size == SZ_WORD) ? 32'h2 : 32'h4;
      base = (mode >= EAC_PCDISP && mode <= EAC_PCMPRE) ? pc : an;
      inner = (mode == EAC_AMPRE || mode == EAC_PCMPRE) ? base + bd + xi : base + bd;
      case (mode)
         EAC_DREG:               e = {29'h0, data_reg_sel};
         EAC_AREG:               e = {29'h0, addr_reg_sel};
         EAC_AIND, EAC_APOST:    e = an;
         EAC_APRE:               e = an - step;
         EAC_ADISP, EAC_PCDISP:  e = base + d16;
         EAC_AIDX8, EAC_PCIDX8:  e = base + d8 + xi;
         EAC_AIDXB, EAC_PCIDXB:  e = base + bd + xi;
         EAC_AMPOST, EAC_PCMPOST: e = mem(inner) + xi + od;
         EAC_AMPRE, EAC_PCMPRE:  e = mem(inner) + od;
         EAC_ABSW:               e = d16;
         EAC_ABSL:               e = ext_data;
         default:                e = (op_size == SZ_BYTE) ? {24'h0, ext_data[7:0]} :
                                     (op_size == SZ_WORD) ? {16'h0, ext_data[15:0]} : ext_data;
      endcase
      start = 1'b1;
      if (r[25] & r[26]) begin
         // frozen clock enable: the request must not be taken
         clk_en = 1'b0;
         repeat (2) @(posedge core_clk);
         #2;
         chk("frozen", 32'h0, {30'h0, done, fetch_req});
         clk_en = 1'b1;
      end
      got = 0;
      seenf = 0;
      for (int i = 0; i < 40 && !got; i++) begin
         @(posedge core_clk);
         #2;
         if (fetch_req && !seenf) begin
            seenf = 1;
            chk("fetch_addr", inner, fetch_addr);
            chk("busy", 32'h1, {31'h0, busy});
         end
         got = done;
      end
      if (!got) begin
         n_mismatch++;
         $display("CHECK FAILED done expected 1 seen 0");
         start = 1'b0;
         timed_out = 1'b1;
         return;
      end
      start = 1'b0;
      chk("fetched", {31'h0, mode inside {EAC_AMPOST, EAC_AMPRE, EAC_PCMPOST, EAC_PCMPRE}}, {31'h0, seenf});
      chk("ea_result", e, ea_result);
      chk("ea_is_reg", {31'h0, mode <= EAC_AREG}, {31'h0, ea_is_reg});
      chk("ea_is_imm", {31'h0, mode == EAC_IMM}, {31'h0, ea_is_imm});
      chk("areg_wb", {31'h0, mode == EAC_APOST || mode == EAC_APRE}, {31'h0, areg_wb});
      if (areg_wb === 1'b1) begin
         chk("areg_wb_val", (mode == EAC_APOST) ? an + step : an - step, areg_wb_val);
         chk("areg_wb_sel", {29'h0, addr_reg_sel}, {29'h0, areg_wb_sel});
      end
      @(posedge core_clk);
      #2;
      $display("test mode %0d finished", m);
   endtask

   // reset, then every mode with corner operands, with suppressed terms, and twice at random
   initial begin
      mode = EAC_DREG;
      timed_out = 1'b0;
      {start, data_reg_sel, addr_reg_sel, index_reg_sel, index_is_addr, index_long} = '0;
      {index_scale, index_supp, bd_size, od_size, op_size, short_disp_byte} = '0;
      {short_disp_word, base_disp, outer_disp, ext_data, pc, dregs, aregs, stall} = '0;
      {rst_b, clk_en, n_mismatch, check_count} = {1'b0, 1'b1, 32'h0, 32'h0};
      lfsr_state = 32'h0000_0029;
      repeat (20) @(posedge core_clk);
      #2;
      rst_b = 1'b1;
      chk("reset_state", 32'h0, {29'h0, done, busy, fetch_req});
      chk("reset_ea", 32'h0, ea_result);
      for (int p = 0; p < 4; p++) begin
         for (int m = 0; m < 18; m++) begin
            if (!timed_out) run_op(m, p);
         end
      end
      close_out();
   end
endmodule
`default_nettype wire
